/* File: src/fma_exec.sv */
/*
 * execution datapath for field moves, loads, multiply,
 * complement, OR and pixel block transfers
 * assumes a bit-addressed memory that answers with mem_ack_i
 * and returns fields right-justified in mem_rdata_i
 */
`timescale 1ns/1ps
`default_nettype none
`include "fma_map.svh"

// Summary of operation
// (RULE1) predecrement both: lower source and dest by field size, then copy field
// (RULE2) offset load: read field at source plus offset into dest register
// (RULE3) postincrement dest: store at old address, then add field size
// (RULE4) offset to offset: both addresses base plus own offset, bases kept
// (RULE5) absolute load: fetch field at source_location into dest register
// (RULE6) absolute to postincrement: store at dest register, then add size
// (RULE7) absolute to absolute: copy field with no register touched
// (RULE8) set_choice picks size and extend pair zero or one
// (RULE9) immediate load: short sign-extended, long full 32 bits
// (RULE10) small constant load leaves status untouched
// (RULE11) low half copy keeps upper half of dest
// (RULE12) high half copy keeps lower half of dest
// (RULE13) signed multiply: even dest gets 64 bits in pair, odd 32
// (RULE14) unsigned multiply with same pair rule
// (RULE15) twos complement negation of dest
// (RULE16) negation also subtracting carry
// (RULE17) no-operation changes nothing but the program counter
// (RULE18) ones complement of dest in place
// (RULE19) dest becomes source OR dest
// (RULE20) dest becomes immediate OR dest
// (RULE21) binary source block: expand 1-bit pixels, combine with dest
// (RULE22) linear source block: combine source pixels with dest
// (RULE23) field size and extend held in status, loaded alone
// (RULE24) narrow fields fill upper bits by extend bit
// (RULE25) memory addressed at bit granularity
module fma_exec (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // instruction issue
    input wire logic instr_valid_i,
    input wire fma_pkg::fma_instr_s instr_i,
    output logic instr_ready_o,
    output logic done_o,
    // bit-addressed memory
    output logic mem_valid_o,
    output var fma_pkg::fma_mem_req_s mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    // observation
    input wire logic [3:0] peek_idx_i,
    output logic [31:0] peek_data_o,
    output var fma_pkg::fma_status_s status_o,
    output logic [31:0] pc_o
);

    // ********************************
    // state and storage
    // ********************************
    typedef enum logic [2:0] {
        S_IDLE, S_SRC, S_DST, S_PB_SRC, S_PB_DST, S_PB_WR
    } fma_state_e;

    fma_state_e state_q, state_d;
    logic [31:0] regs_q [`FMA_NREG];
    fma_pkg::fma_status_s st_q, st_d;
    fma_pkg::fma_instr_s ins_q;
    logic [31:0] sa_q, sa_d, da_q, da_d;
    logic [31:0] fld_q, fld_d;
    logic [5:0] fsz_q;
    logic fe_q;
    logic [15:0] cnt_q, cnt_d;
    logic [31:0] pc_q, peek_q;
    logic done_q, done_d;

    // register file write ports
    logic we0, we1;
    logic [3:0] wi0, wi1;
    logic [31:0] wd0, wd1;

    // ********************************
    // operand selection
    // ********************************
    wire logic start = instr_valid_i && (state_q == S_IDLE);
    wire logic [31:0] rs_v = regs_q[instr_i.src_idx];
    wire logic [31:0] rd_v = regs_q[instr_i.dst_idx];
    // size zero stands for a full 32-bit field
    wire logic [4:0] fs_sel = instr_i.set_choice ? st_q.field_size_one
                                                 : st_q.field_size_zero; // see (RULE8)
    wire logic fe_sel = instr_i.set_choice ? st_q.field_extend_one
                                           : st_q.field_extend_zero; // see (RULE8)
    wire logic [5:0] fsz = (fs_sel == 5'h00) ? `FMA_FULL : {1'b0, fs_sel};
    wire logic [31:0] soff = {{16{instr_i.src_off[15]}}, instr_i.src_off};
    wire logic [31:0] doff = {{16{instr_i.dst_off[15]}}, instr_i.dst_off};
    wire logic [31:0] fsz32 = {26'h0, fsz};
    wire logic [31:0] fszq32 = {26'h0, fsz_q};

    // field mask and sign for any width up to 32
    function automatic logic [31:0] fld_ext(input logic [31:0] v,
                                            input logic [5:0] sz,
                                            input logic sx);
        logic [31:0] m;
        logic sb;
        m = (sz >= `FMA_FULL) ? 32'hffffffff : ((32'h1 << sz) - 32'h1);
        sb = sx && v[sz[4:0] - 5'h01];
        fld_ext = (v & m) | ((sb && sz < `FMA_FULL) ? ~m : 32'h0); // see (RULE24)
    endfunction

    // ********************************
    // arithmetic results
    // ********************************
    wire logic [31:0] mf_s = fld_ext(rs_v, fsz, 1'b1);
    wire logic [31:0] mf_u = fld_ext(rs_v, fsz, 1'b0);
    wire logic signed [63:0] prod_s = $signed({{32{mf_s[31]}}, mf_s})
                                    * $signed({{32{rd_v[31]}}, rd_v}); // see (RULE13)
    wire logic [63:0] prod_u = {32'h0, mf_u} * {32'h0, rd_v}; // see (RULE14)
    wire logic [63:0] prod = (instr_i.op == fma_pkg::FMA_SIGNED_MULTIPLY_OP) ? prod_s : prod_u;
    wire logic [31:0] neg_v = 32'h0 - rd_v; // see (RULE15)
    wire logic [31:0] complement_with_borrow_op_v = neg_v - {31'h0, st_q.carry}; // see (RULE16)
    wire logic [31:0] ldi_s = {{16{instr_i.imm[15]}}, instr_i.imm[15:0]}; // see (RULE9)
    wire logic even_dst = ~instr_i.dst_idx[0];
    wire logic [3:0] dst_pair = instr_i.dst_idx + 4'h1;

    // pixel path; binary source expands to the two colors in imm
    wire logic bin_q = (ins_q.op == fma_pkg::FMA_PB_BIN);
    wire logic [5:0] spx = bin_q ? 6'h01 : `FMA_PIX;
    wire logic [7:0] exp_pix = mem_rdata_i[0] ? ins_q.imm[7:0]
                                              : ins_q.imm[15:8]; // see (RULE21)
    wire logic [7:0] dpx = mem_rdata_i[7:0];
    wire logic [7:0] rop_v = (ins_q.rop == fma_pkg::FMA_ROP_OR) ? (fld_q[7:0] | dpx) :
                             (ins_q.rop == fma_pkg::FMA_ROP_AND) ? (fld_q[7:0] & dpx) :
                             (ins_q.rop == fma_pkg::FMA_ROP_XOR) ? (fld_q[7:0] ^ dpx) :
                             fld_q[7:0]; // see (RULE22)
    wire logic dst_to_reg = (ins_q.op == fma_pkg::FMA_MV_OFF_R)
                         || (ins_q.op == fma_pkg::FMA_MV_ABS_R);
    wire logic dst_postinc = (ins_q.op == fma_pkg::FMA_MV_OFF_PI)
                          || (ins_q.op == fma_pkg::FMA_MV_ABS_PI);

    // ********************************
    // memory request
    // ********************************
    // bit addresses go out unchanged so fields may straddle words
    assign mem_valid_o = (state_q != S_IDLE);
    assign mem_req_o.addr = (state_q == S_SRC || state_q == S_PB_SRC) ? sa_q
                                                                      : da_q; // see (RULE25)
    assign mem_req_o.size = (state_q == S_PB_SRC) ? spx :
                            (state_q == S_PB_DST || state_q == S_PB_WR) ? `FMA_PIX : fsz_q;
    assign mem_req_o.we = (state_q == S_DST) || (state_q == S_PB_WR);
    assign mem_req_o.wdata = fld_q;
    assign mem_req_o.xy = ins_q.dst_xy && (state_q == S_PB_DST || state_q == S_PB_WR);

    // ********************************
    // next state, writes and status
    // ********************************
    always_comb begin
        state_d = state_q;
        st_d = st_q;
        sa_d = sa_q;
        da_d = da_q;
        fld_d = fld_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        we0 = 1'b0;
        we1 = 1'b0;
        wi0 = instr_i.dst_idx;
        wi1 = instr_i.src_idx;
        wd0 = 32'h0;
        wd1 = 32'h0;
        case (state_q)
            S_IDLE: begin
                if (start) begin
                    done_d = 1'b1;
                    we0 = 1'b1;
                    case (instr_i.op)
                        fma_pkg::FMA_NOP: we0 = 1'b0; // see (RULE17)
                        fma_pkg::FMA_MV_PP: begin
                            // both pointers drop before the copy
                            wd0 = rd_v - fsz32; // see (RULE1)
                            we1 = 1'b1;
                            wd1 = rs_v - fsz32;
                            sa_d = rs_v - fsz32;
                            da_d = rd_v - fsz32;
                            state_d = S_SRC;
                            done_d = 1'b0;
                        end
                        fma_pkg::FMA_MV_OFF_R, fma_pkg::FMA_MV_OFF_PI,
                        fma_pkg::FMA_MV_OFF_OFF: begin
                            we0 = 1'b0;
                            sa_d = rs_v + soff; // see (RULE2)
                            da_d = (instr_i.op == fma_pkg::FMA_MV_OFF_OFF) ? rd_v + doff
                                                                           : rd_v; // see (RULE4)
                            state_d = S_SRC;
                            done_d = 1'b0;
                        end
                        fma_pkg::FMA_MV_ABS_R, fma_pkg::FMA_MV_ABS_PI,
                        fma_pkg::FMA_MV_ABS_ABS: begin
                            we0 = 1'b0;
                            sa_d = instr_i.source_location; // see (RULE5)
                            da_d = (instr_i.op == fma_pkg::FMA_MV_ABS_ABS)
                                 ? instr_i.dest_location : rd_v; // see (RULE7)
                            state_d = S_SRC;
                            done_d = 1'b0;
                        end
                        fma_pkg::FMA_LDI_S: wd0 = ldi_s; // see (RULE9)
                        fma_pkg::FMA_LDI_L: wd0 = instr_i.imm; // see (RULE9)
                        fma_pkg::FMA_LDK: wd0 = {27'h0, instr_i.small_const}; // see (RULE10)
                        fma_pkg::FMA_LOWCPY: wd0 = {rd_v[31:16], rs_v[15:0]}; // see (RULE11)
                        fma_pkg::FMA_HICPY: wd0 = {rs_v[31:16], rd_v[15:0]}; // see (RULE12)
                        fma_pkg::FMA_SIGNED_MULTIPLY_OP, fma_pkg::FMA_UNSIGNED_MULTIPLY_OP: begin
                            // even destination takes the pair, high word first
                            wd0 = even_dst ? prod[63:32] : prod[31:0]; // see (RULE13)
                            we1 = even_dst; // see (RULE14)
                            wi1 = dst_pair;
                            wd1 = prod[31:0];
                        end
                        fma_pkg::FMA_NEG: begin
                            wd0 = neg_v; // see (RULE15)
                            st_d.carry = (rd_v != 32'h0);
                        end
                        fma_pkg::FMA_COMPLEMENT_WITH_BORROW_OP: begin
                            wd0 = complement_with_borrow_op_v; // see (RULE16)
                            st_d.carry = (rd_v != 32'h0) || st_q.carry;
                        end
                        fma_pkg::FMA_NOT: wd0 = ~rd_v; // see (RULE18)
                        fma_pkg::FMA_OR: wd0 = rs_v | rd_v; // see (RULE19)
                        fma_pkg::FMA_ORI: wd0 = instr_i.imm | rd_v; // see (RULE20)
                        fma_pkg::FMA_SETF: begin
                            we0 = 1'b0;
                            // only the chosen pair moves
                            if (instr_i.set_choice) begin
                                st_d.field_size_one = instr_i.new_fs; // see (RULE23)
                                st_d.field_extend_one = instr_i.new_fe;
                            end else begin
                                st_d.field_size_zero = instr_i.new_fs; // see (RULE23)
                                st_d.field_extend_zero = instr_i.new_fe;
                            end
                        end
                        default: begin
                            // pixel block transfer from the two start pointers
                            we0 = 1'b0;
                            sa_d = rs_v;
                            da_d = rd_v;
                            cnt_d = instr_i.pix_count;
                            if (instr_i.pix_count != 16'h0) begin
                                state_d = S_PB_SRC;
                                done_d = 1'b0;
                            end
                        end
                    endcase
                end
            end
            S_SRC: begin
                if (mem_ack_i) begin
                    if (dst_to_reg) begin
                        we0 = 1'b1;
                        wi0 = ins_q.dst_idx;
                        wd0 = fld_ext(mem_rdata_i, fsz_q, fe_q); // see (RULE24)
                        done_d = 1'b1;
                        state_d = S_IDLE;
                    end else begin
                        fld_d = fld_ext(mem_rdata_i, fsz_q, 1'b0);
                        state_d = S_DST;
                    end
                end
            end
            S_DST: begin
                if (mem_ack_i) begin
                    // pointer moves only once the old address is written
                    we0 = dst_postinc; // see (RULE3)
                    wi0 = ins_q.dst_idx;
                    wd0 = regs_q[ins_q.dst_idx] + fszq32; // see (RULE6)
                    done_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            S_PB_SRC: begin
                if (mem_ack_i) begin
                    fld_d = {24'h0, bin_q ? exp_pix : mem_rdata_i[7:0]}; // see (RULE21)
                    state_d = S_PB_DST;
                end
            end
            S_PB_DST: begin
                if (mem_ack_i) begin
                    fld_d = {24'h0, rop_v}; // see (RULE22)
                    state_d = S_PB_WR;
                end
            end
            default: begin
                if (mem_ack_i) begin
                    sa_d = sa_q + {26'h0, spx};
                    da_d = da_q + {26'h0, `FMA_PIX};
                    cnt_d = cnt_q - 16'h1;
                    done_d = (cnt_q == 16'h1);
                    state_d = (cnt_q == 16'h1) ? S_IDLE : S_PB_SRC;
                end
            end
        endcase
    end

    // ********************************
    // register file
    // ********************************
    // one entry per register, port zero has priority
    for (genvar g = 0; g < `FMA_NREG; g++) begin : g_reg
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                regs_q[g] <= 32'h0;
            end else if (we0 && wi0 == 4'(g)) begin
                regs_q[g] <= wd0;
            end else if (we1 && wi1 == 4'(g)) begin
                regs_q[g] <= wd1;
            end
        end
    end

    // sequencing flops
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_q <= S_IDLE;
            st_q <= {`FMA_C_RST, `FMA_FE_RST, `FMA_FS_RST, `FMA_FE_RST, `FMA_FS_RST};
            done_q <= 1'b0;
            pc_q <= 32'h0;
        end else begin
            state_q <= state_d;
            st_q <= st_d;
            done_q <= done_d;
            pc_q <= pc_q + {31'h0, done_d}; // see (RULE17)
        end
    end

    // datapath flops, loaded at issue and otherwise held when idle, except peek_q, which follows peek_idx_i every cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ins_q <= '0;
            sa_q <= 32'h0;
            da_q <= 32'h0;
            fld_q <= 32'h0;
            cnt_q <= 16'h0;
            fsz_q <= `FMA_FULL;
            fe_q <= 1'b0;
            peek_q <= 32'h0;
        end else begin
            if (start) begin
                ins_q <= instr_i;
                fsz_q <= fsz;
                fe_q <= fe_sel;
            end
            sa_q <= sa_d;
            da_q <= da_d;
            fld_q <= fld_d;
            cnt_q <= cnt_d;
            peek_q <= regs_q[peek_idx_i];
        end
    end

    assign instr_ready_o = (state_q == S_IDLE);
    assign done_o = done_q;
    assign peek_data_o = peek_q;
    assign status_o = st_q;
    assign pc_o = pc_q;

    // ********************************
    // checks
    // ********************************
    sequence s_store_acked;
        (state_q == S_DST) && mem_ack_i;
    endsequence

    a_ldk_status_keep: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_LDK |=> st_q == $past(st_q)) // see (RULE10)
        else $error("small constant load changed status");
    a_postinc_step: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_store_acked and dst_postinc |=>
        regs_q[ins_q.dst_idx] == $past(regs_q[ins_q.dst_idx]) + fszq32) // see (RULE3)
        else $error("postincrement did not add field size");
    a_predec_src: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_MV_PP |=>
        state_q == S_SRC && mem_req_o.addr == $past(rs_v) - $past(fsz32)) // see (RULE1)
        else $error("predecrement source address wrong");
    a_offset_addr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_MV_OFF_OFF |=>
        sa_q == $past(rs_v) + $past(soff) && da_q == $past(rd_v) + $past(doff)) // see (RULE4)
        else $error("offset addresses wrong");
    a_low_copy: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_LOWCPY |=>
        regs_q[$past(instr_i.dst_idx)][31:16] == $past(rd_v[31:16])) // see (RULE11)
        else $error("low half copy disturbed upper half");
    a_high_copy: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_HICPY |=>
        regs_q[$past(instr_i.dst_idx)][15:0] == $past(rd_v[15:0])) // see (RULE12)
        else $error("high half copy disturbed lower half");
    a_or_reg: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_OR |=>
        regs_q[$past(instr_i.dst_idx)] == ($past(rs_v) | $past(rd_v))) // see (RULE19)
        else $error("register OR result wrong");
    a_not_reg: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_NOT |=>
        regs_q[$past(instr_i.dst_idx)] == ~$past(rd_v)) // see (RULE18)
        else $error("complement result wrong");
    a_neg_reg: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_NEG |=>
        regs_q[$past(instr_i.dst_idx)] + $past(rd_v) == 32'h0) // see (RULE15)
        else $error("negation result wrong");
    a_nop_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_NOP |=>
        done_o && !mem_valid_o && pc_o == $past(pc_o) + 32'h1) // see (RULE17)
        else $error("no-operation did more than advance");
    a_abs_abs_addr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start && instr_i.op == fma_pkg::FMA_MV_ABS_ABS |=>
        sa_q == $past(instr_i.source_location) && da_q == $past(instr_i.dest_location)) // see (RULE7)
        else $error("absolute transfer addresses wrong");

endmodule // fma_exec

`default_nettype wire

/* File: src/fma_map.svh */
/*
 * constants of the field-move execution block
 * assumes a 32-bit register file of sixteen entries
 */
`ifndef FMA_MAP_SVH
`define FMA_MAP_SVH

// datapath widths
`define FMA_W 32
`define FMA_NREG 16
`define FMA_HALF 16
// full field encoded as size zero
`define FMA_FULL 6'h20
// pixel size for block transfers
`define FMA_PIX 6'h08
// status reset values
`define FMA_FS_RST 5'h00
`define FMA_FE_RST 1'b0
`define FMA_C_RST 1'b0

`endif

/* File: src/fma_pkg.sv */
/*
 * types of the field-move execution block
 * assumes fma_map.svh for widths
 */
package fma_pkg;

    // instruction codes
    typedef enum logic [4:0] {
        FMA_NOP, FMA_MV_PP, FMA_MV_OFF_R, FMA_MV_OFF_PI,
        FMA_MV_OFF_OFF, FMA_MV_ABS_R, FMA_MV_ABS_PI,
        FMA_MV_ABS_ABS, FMA_LDI_S, FMA_LDI_L, FMA_LDK,
        FMA_LOWCPY, FMA_HICPY, FMA_SIGNED_MULTIPLY_OP, FMA_UNSIGNED_MULTIPLY_OP, FMA_NEG,
        FMA_COMPLEMENT_WITH_BORROW_OP, FMA_NOT, FMA_OR, FMA_ORI, FMA_SETF,
        FMA_PB_BIN, FMA_PB_LIN
    } fma_op_e;

    // pixel combine operations
    typedef enum logic [1:0] {
        FMA_ROP_SRC, FMA_ROP_OR, FMA_ROP_AND, FMA_ROP_XOR
    } fma_rop_e;

    // one issued instruction
    typedef struct packed {
        fma_op_e op;
        logic [3:0] src_idx;
        logic [3:0] dst_idx;
        logic set_choice;
        logic [15:0] src_off;
        logic [15:0] dst_off;
        logic [31:0] imm;
        logic [31:0] source_location;
        logic [31:0] dest_location;
        logic [4:0] new_fs;
        logic new_fe;
        logic [4:0] small_const;
        logic [15:0] pix_count;
        fma_rop_e rop;
        logic dst_xy;
    } fma_instr_s;

    // status register fields
    typedef struct packed {
        logic carry;
        logic field_extend_one;
        logic [4:0] field_size_one;
        logic field_extend_zero;
        logic [4:0] field_size_zero;
    } fma_status_s;

    // bit-addressed memory request
    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] size;
        logic we;
        logic [31:0] wdata;
        logic xy;
    } fma_mem_req_s;

endpackage

/* File: verif/fma_mem_model.sv */
/*
 * bit-addressed memory partner of the field-move block
 * assumes one request at a time, held until acknowledged
 */
`timescale 1ns/1ps
`default_nettype none
// ****
// memory model
// ****
module fma_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request side
    input wire logic valid_i,
    input wire fma_pkg::fma_mem_req_s req_i,
    input wire logic [1:0] wait_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic bits_q [8192];
    logic [1:0] cnt_q;
    logic tog_q = 1'b0;
    // fields are right-justified and may start on any bit
    function automatic logic [31:0] get(input logic [31:0] a, input logic [5:0] sz = 6'h20);
        for (int i = 0; i < 32; i++) get[i] = (i < sz) ? bits_q[(a + i) % 8192] : 1'b0;
    endfunction
    task automatic put(input logic [31:0] a, input logic [31:0] v, input logic [5:0] sz = 6'h20);
        for (int i = 0; i < sz; i++) bits_q[(a + i) % 8192] = v[i];
    endtask
    // ack after wait_i idle cycles; data lines toggle outside ack so stale data never matches
    always @(posedge clk_i) begin
        tog_q <= ~tog_q;
        if (rst_i || !valid_i || ack_o) begin
            ack_o <= 1'b0;
            cnt_q <= 2'h0;
            rdata_o <= {32{tog_q}};
        end else if (cnt_q == wait_i) begin
            ack_o <= 1'b1;
            rdata_o <= get(req_i.addr, req_i.size);
            if (req_i.we) put(req_i.addr, req_i.wdata, req_i.size);
        end else begin
            cnt_q <= cnt_q + 2'h1;
            rdata_o <= {32{tog_q}};
        end
    end
endmodule // fma_mem_model
`default_nettype wire

/* File: verif/tb.sv */
/*
 * self-checking bench of the field-move block
 * assumes fma_mem_model as the memory beside it
 */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb;
    logic core_clk_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0, mem_ack_i, instr_ready_o, done_o, mem_valid_o;
    logic [31:0] mem_rdata_i, peek_data_o, pc_o;
    logic [3:0] peek_idx_i = 4'h0;
    logic [1:0] mwait = 2'h0;
    logic [63:0] p;
    fma_pkg::fma_instr_s instr_i = '0;
    fma_pkg::fma_mem_req_s mem_req_o;
    fma_pkg::fma_status_s status_o;
    int err_count = 0, checks_done = 0, n;
    // 125 MHz
    always #4 core_clk_i = ~core_clk_i;
    fma_exec i_fma_exec(.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o), .mem_valid_o(mem_valid_o),
        .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .peek_idx_i(peek_idx_i),
        .peek_data_o(peek_data_o), .status_o(status_o), .pc_o(pc_o));
    fma_mem_model i_fma_mem_model(.clk_i(core_clk_i), .rst_i(sys_rst_i), .valid_i(mem_valid_o),
        .req_i(mem_req_o), .wait_i(mwait), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    task automatic final_report;
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // offer one instruction, then wait a bounded time for its completion pulse
    task automatic ex(input fma_pkg::fma_op_e op, input logic [3:0] s, input logic [3:0] d);
        instr_i.op = op;
        instr_i.src_idx = s;
        instr_i.dst_idx = d;
        @(posedge core_clk_i);
        #1 instr_valid_i = 1'b1;
        n = 0;
        while (instr_ready_o !== 1'b1 && n < 99) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        @(posedge core_clk_i);
        #1 instr_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 99) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        if (n >= 99) begin
            err_count++;
            $display("unexpected at %0t: no completion", $time);
            final_report;
        end
    endtask
    // peek is registered, so two edges before the value is settled
    task automatic cr(input logic [3:0] i, input logic [31:0] e);
        peek_idx_i = i;
        repeat (2) @(posedge core_clk_i);
        #1 chk(peek_data_o, e);
    endtask
    task automatic ld(input logic [3:0] d, input logic [31:0] v);
        instr_i.imm = v;
        ex(fma_pkg::FMA_LDI_L, 4'h0, d);
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        #1 sys_rst_i = 1'b0;
        chk(32'(status_o), 32'h0);
        ld(4'h2, 32'h12345678); cr(4'h2, 32'h12345678);
        instr_i.imm = 32'h00008001;
        ex(fma_pkg::FMA_LDI_S, 4'h0, 4'h3); cr(4'h3, 32'hffff8001);
        instr_i.small_const = 5'h1f;
        ex(fma_pkg::FMA_LDK, 4'h0, 4'h4); cr(4'h4, 32'h1f); chk(32'(status_o), 32'h0);
        ex(fma_pkg::FMA_LOWCPY, 4'h2, 4'h3); cr(4'h3, 32'hffff5678);
        ex(fma_pkg::FMA_HICPY, 4'h2, 4'h4); cr(4'h4, 32'h1234001f);
        ex(fma_pkg::FMA_OR, 4'h3, 4'h4); cr(4'h4, 32'hffff567f);
        instr_i.imm = 32'h0000a080;
        ex(fma_pkg::FMA_ORI, 4'h0, 4'h4); cr(4'h4, 32'hfffff6ff);
        ex(fma_pkg::FMA_NOT, 4'h0, 4'h4); cr(4'h4, 32'h00000900);
        ex(fma_pkg::FMA_NOP, 4'h0, 4'h4); cr(4'h4, 32'h00000900); chk(pc_o, 32'h9);
        instr_i.set_choice = 1'b1;
        instr_i.new_fs = 5'h08;
        instr_i.new_fe = 1'b1;
        ex(fma_pkg::FMA_SETF, 4'h0, 4'h0); chk(32'(status_o), 32'h0a00);
        i_fma_mem_model.put(32'd100, 32'h00000080);
        instr_i.source_location = 32'd100;
        ex(fma_pkg::FMA_MV_ABS_R, 4'h0, 4'h5); cr(4'h5, 32'hffffff80);
        instr_i.set_choice = 1'b0;
        ex(fma_pkg::FMA_NEG, 4'h0, 4'h5); cr(4'h5, 32'h80); chk(32'(status_o), 32'h1a00);
        ex(fma_pkg::FMA_COMPLEMENT_WITH_BORROW_OP, 4'h0, 4'h5); cr(4'h5, 32'hffffff7f);
        p = longint'(305419896) * -129;
        ex(fma_pkg::FMA_SIGNED_MULTIPLY_OP, 4'h5, 4'h2); cr(4'h2, p[63:32]); cr(4'h3, p[31:0]);
        p = 64'hffffff7f * 64'h900;
        ex(fma_pkg::FMA_UNSIGNED_MULTIPLY_OP, 4'h4, 4'h5); cr(4'h5, p[31:0]); cr(4'h6, 32'h0);
        // slow memory from here on
        mwait = 2'h2;
        i_fma_mem_model.put(32'h200, 32'hcafe1234);
        instr_i.source_location = 32'h200;
        instr_i.dest_location = 32'h303;
        ex(fma_pkg::FMA_MV_ABS_ABS, 4'h0, 4'h0); chk(i_fma_mem_model.get(32'h303), 32'hcafe1234);
        ld(4'ha, 32'h40); ld(4'hb, 32'h400); ld(4'hc, 32'h500);
        i_fma_mem_model.put(32'h50, 32'h5a5a0001);
        instr_i.src_off = 16'h10;
        ex(fma_pkg::FMA_MV_OFF_R, 4'ha, 4'hd); cr(4'hd, 32'h5a5a0001);
        i_fma_mem_model.put(32'h3e0, 32'h11112222);
        ex(fma_pkg::FMA_MV_PP, 4'hb, 4'hc); cr(4'hb, 32'h3e0); cr(4'hc, 32'h4e0);
        chk(i_fma_mem_model.get(32'h4e0), 32'h11112222);
        ex(fma_pkg::FMA_MV_OFF_PI, 4'ha, 4'hc); chk(i_fma_mem_model.get(32'h4e0), 32'h5a5a0001);
        cr(4'hc, 32'h500);
        ex(fma_pkg::FMA_MV_ABS_PI, 4'h0, 4'hc); chk(i_fma_mem_model.get(32'h500), 32'hcafe1234);
        cr(4'hc, 32'h520);
        instr_i.dst_off = 16'h20;
        ex(fma_pkg::FMA_MV_OFF_OFF, 4'ha, 4'hb); chk(i_fma_mem_model.get(32'h400), 32'h5a5a0001);
        cr(4'ha, 32'h40); cr(4'hb, 32'h3e0);
        i_fma_mem_model.put(32'h40, 32'h2, 6'h2);
        instr_i.imm = 32'h5a3c;
        instr_i.pix_count = 16'h2;
        ex(fma_pkg::FMA_PB_BIN, 4'ha, 4'hc); chk(i_fma_mem_model.get(32'h520, 6'h10), 32'h3c5a);
        instr_i.rop = fma_pkg::FMA_ROP_OR;
        ex(fma_pkg::FMA_PB_LIN, 4'hc, 4'hb); chk(i_fma_mem_model.get(32'h3e0, 6'h10), 32'h3e7a);
        final_report;
    end
endmodule // tb
`default_nettype wire
